// ===== verilog/cdc_i2c_pkg.sv
package cdc_i2c_pkg;

  // ==========================================================
  // bus addresses and command bytes
  localparam logic [6:0] SLAVE_ADDR = 7'h48;
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam logic [7:0] SOFT_RESET_PTR = 8'hBF;
  localparam logic [7:0] GCALL_RESET_CMD = 8'h06;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int RELOAD_MAX_US = 200;
  localparam int RELOAD_CYCLES = RELOAD_MAX_US * CLK_MHZ;
  localparam logic [7:0] LAST_BIT = 8'h07;

  // ==========================================================
  // protocol states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b011,
    ST_RX = 3'b010,
    ST_TX = 3'b110,
    ST_MACK = 3'b111,
    ST_WAIT = 3'b101
  } state_t;

  // byte roles within a write
  typedef enum logic [1:0] {
    BY_ADDR = 2'h0,
    BY_PTR = 2'h1,
    BY_DATA = 2'h2,
    BY_GCALL = 2'h3
  } byte_t;

endpackage

// ===== verilog/cdc_i2c_slave_port.sv
// Functional notes
// - SDA falling while SCL high is start.
// - Shift eight address bits, MSB first.
// - Ack on address match, else idle.
// - Direction bit selects receive or transmit.
// - Respond to 0x90 write, 0x91 read.
// - First written byte loads the pointer.
// - SDA rising while SCL high is stop.
// - Stop returns idle and clears pointer.
// - Data bytes stored at pointer, pointer increments.
// - Repeated start like start, pointer kept.
// - Read sends pointed register, increments on ack.
// - Master nack ends read, no increment.
// - Pointer itself is never readable.
// - Reads continue past map until nack/start/stop.
// - Invalid address writes dropped but acknowledged.
// - Pointer byte 0xBF resets the device.
// - No acknowledge during default reload time.
// - Acknowledge general call, receive next byte.
// - General call byte 0x06 resets device.
// - Other general call bytes are not acknowledged.
module cdc_i2c_slave_port
  import cdc_i2c_pkg::*;
#(
  parameter int RELOAD_CNT = RELOAD_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // register side
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_valid,
  output logic defaults_reload,
  output logic busy
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_q;
    logic sda_q;
    state_t st;
    byte_t role;
    logic [7:0] sh;
    logic [7:0] bitn;
    logic rd;
    logic ack_ok;
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic wr;
    logic reload;
    logic [31:0] hold;
    logic busy;
    logic oe;
  } regs_t;

  regs_t r;
  regs_t next_r;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  assign scl = r.scl_s[1];
  assign sda = r.sda_s[1];
  assign scl_rise = scl && !r.scl_q;
  assign scl_fall = !scl && r.scl_q;
  assign start_c = scl && r.scl_q && r.sda_q && !sda;
  assign stop_c = scl && r.scl_q && !r.sda_q && sda;

  // ==========================================================
  // next state
  always_comb begin
    next_r = r;
    next_r.scl_s = {r.scl_s[0], scl_in};
    next_r.sda_s = {r.sda_s[0], sda_in};
    next_r.scl_q = scl;
    next_r.sda_q = sda;
    next_r.wr = 1'b0;
    next_r.reload = 1'b0;
    if (r.hold != 32'h0) begin
      // reload in progress: ignore the bus entirely
      next_r.hold = r.hold - 32'h1;
      next_r.st = ST_IDLE;
      next_r.oe = 1'b0;
      next_r.ptr = PTR_RESET;
    end else if (stop_c) begin
      next_r.st = ST_IDLE;
      next_r.ptr = PTR_RESET;
      next_r.oe = 1'b0;
    end else if (start_c) begin
      // pointer kept across repeated start
      next_r.st = ST_ADDR;
      next_r.role = BY_ADDR;
      next_r.bitn = 8'h0;
      next_r.oe = 1'b0;
    end else begin
      case (r.st)
        ST_IDLE: begin
          next_r.oe = 1'b0;
        end
        ST_ADDR, ST_RX: begin
          // count on rises: the fall that ends a start is not a bit
          if (scl_rise) begin
            next_r.sh = {r.sh[6:0], sda};
            next_r.bitn = r.bitn + 8'h1;
          end
          if (scl_fall) begin
            if (r.bitn > LAST_BIT) begin
              next_r.st = ST_ACK;
              next_r.bitn = 8'h0;
              next_r.ack_ok = 1'b0;
              case (r.role)
                BY_ADDR: begin
                  if (r.sh[7:1] == SLAVE_ADDR) begin
                    next_r.ack_ok = 1'b1;
                    next_r.rd = r.sh[0];
                  end else if (r.sh == {GCALL_ADDR, 1'b0}) begin
                    next_r.ack_ok = 1'b1;
                    next_r.rd = 1'b0;
                  end
                end
                BY_PTR: begin
                  next_r.ack_ok = 1'b1;
                  next_r.ptr = r.sh;
                end
                BY_DATA: begin
                  next_r.ack_ok = 1'b1;
                  next_r.wdata = r.sh;
                  next_r.wr = reg_valid;
                end
                default: begin
                  next_r.ack_ok = (r.sh == GCALL_RESET_CMD);
                end
              endcase
              next_r.oe = next_r.ack_ok;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_r.oe = 1'b0;
            if (!r.ack_ok) begin
              next_r.st = ST_IDLE;
            end else begin
              case (r.role)
                BY_ADDR: begin
                  if (r.sh == {GCALL_ADDR, 1'b0}) begin
                    next_r.role = BY_GCALL;
                    next_r.st = ST_RX;
                  end else if (r.rd) begin
                    next_r.st = ST_TX;
                    next_r.sh = reg_rdata;
                    next_r.oe = !reg_rdata[7];
                  end else begin
                    next_r.role = BY_PTR;
                    next_r.st = ST_RX;
                  end
                end
                BY_PTR: begin
                  if (r.ptr == SOFT_RESET_PTR) begin
                    next_r.reload = 1'b1;
                    next_r.hold = 32'(RELOAD_CNT);
                    next_r.st = ST_IDLE;
                  end else begin
                    next_r.role = BY_DATA;
                    next_r.st = ST_RX;
                  end
                end
                BY_DATA: begin
                  next_r.ptr = r.ptr + 8'h1;
                  next_r.st = ST_RX;
                end
                default: begin
                  next_r.reload = 1'b1;
                  next_r.hold = 32'(RELOAD_CNT);
                  next_r.st = ST_IDLE;
                end
              endcase
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (r.bitn == LAST_BIT) begin
              next_r.bitn = 8'h0;
              next_r.oe = 1'b0;
              next_r.st = ST_MACK;
            end else begin
              next_r.bitn = r.bitn + 8'h1;
              next_r.sh = {r.sh[6:0], 1'b0};
              next_r.oe = !r.sh[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            if (sda) begin
              next_r.st = ST_IDLE;
            end else begin
              next_r.ptr = r.ptr + 8'h1;
              next_r.st = ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (scl_fall) begin
            next_r.st = ST_TX;
            next_r.sh = reg_rdata;
            next_r.oe = !reg_rdata[7];
          end
        end
        default: begin
          next_r.st = ST_IDLE;
        end
      endcase
    end
    next_r.busy = (next_r.hold != 32'h0);
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      r <= '0;
      r.scl_s <= 2'h3;
      r.sda_s <= 2'h3;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
      r.st <= ST_IDLE;
      r.role <= BY_ADDR;
    end else begin
      r <= next_r;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = r.oe;
  assign reg_addr = r.ptr;
  assign reg_wdata = r.wdata;
  assign reg_wr = r.wr;
  assign defaults_reload = r.reload;
  assign busy = r.busy;

  // ==========================================================
  // checks
  sequence stop_seen;
    stop_c && r.hold == 32'h0;
  endsequence

  sequence ptr_cleared;
    ##1 r.ptr == PTR_RESET && r.st == ST_IDLE;
  endsequence

  stop_clears_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    stop_seen |-> ptr_cleared)
    else $error("stop did not clear pointer");

  start_addr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    start_c && r.hold == 32'h0 |=> r.st == ST_ADDR)
    else $error("start not detected");

  busy_nack_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    busy |-> !sda_oe)
    else $error("drove bus during reload");

  reload_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    defaults_reload |-> busy [*8])
    else $error("reload window too short");

  drive_low_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    sda_out == 1'b0)
    else $error("sda driven high");

  wr_ptr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_wr |-> r.st == ST_ACK && r.role == BY_DATA)
    else $error("write outside data ack");

  nack_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    r.st == ST_MACK && scl_rise && sda && !stop_c && !start_c
      && !busy |=> r.st == ST_IDLE && $stable(r.ptr))
    else $error("nack did not end read");

  gcall_ack_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    r.st == ST_ACK && r.role == BY_GCALL && r.sh != GCALL_RESET_CMD
      |-> !sda_oe)
    else $error("acked bad general call");

  ack_match_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    r.st == ST_ACK && r.role == BY_ADDR && sda_oe |->
      r.sh[7:1] == SLAVE_ADDR || r.sh == 8'h00)
    else $error("acked foreign address");

endmodule

// ===== sim/i2c_master_model.sv
module i2c_master_model (
  // bus wires
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 10ps;
  localparam realtime Q = 31.25ns;
  // ==========================================
  // bus master, 125 ns bit time, scl idle high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic bit_x(input logic b, output logic r);
    sda_low = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic byte_x(input logic [7:0] d, input logic ai,
                        output logic [7:0] r, output logic ao);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(ai, ao);
  endtask
  // sda falls while scl high
  task automatic start_c();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  // sda rises while scl high
  task automatic stop_c();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
endmodule

// ===== sim/tb_cdc_i2c_slave_port.sv
module tb_cdc_i2c_slave_port import cdc_i2c_pkg::*;;
  timeunit 1ns;
  timeprecision 10ps;
  localparam int RL = 300;
  logic core_clk, reset_n, scl, sda_low, sda, sda_out, sda_oe, ack;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, d, p;
  logic reg_wr, reg_valid, defaults_reload, busy;
  logic [7:0] mem [256];
  logic [7:0] em [256];
  int n_mismatch = 0, cmp_count = 0, n_reload = 0, cyc = 0;
  // open-drain wire with pull-up
  assign sda = !(sda_low || (sda_oe && !sda_out));
  assign reg_rdata = mem[reg_addr];
  assign reg_valid = (reg_addr >= 8'h05) && (reg_addr <= 8'h1A);
  cdc_i2c_slave_port #(.RELOAD_CNT(RL)) cdc_i2c_slave_port_i (
    .core_clk(core_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .reg_valid(reg_valid), .defaults_reload(defaults_reload), .busy(busy));
  i2c_master_model i2c_master_model_i (.scl(scl), .sda_low(sda_low),
    .sda(sda));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = !core_clk;
  end
  // ==========================================
  // register file, reload counter, timeout
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    // no gating here: the design must drop invalid writes itself
    if (reg_wr) mem[reg_addr] <= reg_wdata;
    if (defaults_reload) n_reload <= n_reload + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic summarize();
    $display("counts: compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] b, input logic a, input string m);
    i2c_master_model_i.byte_x(b, 1'b1, rd, ack);
    chk({7'h0, ack}, {7'h0, a}, m);
  endtask
  task automatic ptr_is(input logic [7:0] e, input string m);
    repeat (4) @(negedge core_clk);
    chk(reg_addr, e, m);
    // keep later bus edges off the core clock edges
    #3;
  endtask
  // ==========================================
  // tests
  initial begin
    reset_n = 1'b0;
    void'($urandom(32'hBD7AE009));
    foreach (mem[i]) mem[i] = 8'($urandom);
    em = mem;
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    ptr_is(PTR_RESET, "reset ptr");
    // write burst running past the writable map
    p = 8'(25 + $urandom_range(0, 1));
    i2c_master_model_i.start_c();
    wr(8'h90, 1'b0, "wr addr");
    wr(p, 1'b0, "ptr byte");
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      wr(d, 1'b0, "data ack");
      if (p + i <= 8'h1A) em[8'(p + i)] = d;
    end
    ptr_is(8'(p + 3), "ptr inc");
    i2c_master_model_i.stop_c();
    ptr_is(PTR_RESET, "stop ptr");
    $display("test write done");
    // read back in one burst after repeated start
    i2c_master_model_i.start_c();
    wr(8'h90, 1'b0, "wr addr");
    wr(p, 1'b0, "ptr byte");
    i2c_master_model_i.start_c();
    wr(8'h91, 1'b0, "rd addr");
    for (int i = 0; i < 4; i++) begin
      i2c_master_model_i.byte_x(8'hFF, i == 3, rd, ack);
      chk(rd, em[8'(p + i)], "read data");
    end
    ptr_is(8'(p + 3), "nack ptr");
    i2c_master_model_i.stop_c();
    ptr_is(PTR_RESET, "stop ptr");
    $display("test read done");
    // foreign addresses
    for (int i = 0; i < 4; i++) begin
      i2c_master_model_i.start_c();
      wr(8'h90 ^ (8'h02 << i), 1'b1, "foreign");
      i2c_master_model_i.stop_c();
    end
    $display("test foreign done");
    // general call, other command then reset command
    i2c_master_model_i.start_c();
    wr(8'h00, 1'b0, "gcall");
    wr(8'h07, 1'b1, "gcall other");
    i2c_master_model_i.stop_c();
    chk(8'(n_reload), 8'h00, "no reload");
    i2c_master_model_i.start_c();
    wr(8'h00, 1'b0, "gcall");
    wr(GCALL_RESET_CMD, 1'b0, "gcall reset");
    i2c_master_model_i.stop_c();
    i2c_master_model_i.start_c();
    wr(8'h90, 1'b1, "busy addr");
    i2c_master_model_i.stop_c();
    chk(8'(n_reload), 8'h01, "reload gcall");
    chk({7'h0, busy}, 8'h01, "busy held");
    $display("test general call done");
    // soft reset by pointer byte, master waits out the reload
    repeat (RL) @(negedge core_clk);
    #3;
    chk({7'h0, busy}, 8'h00, "busy over");
    i2c_master_model_i.start_c();
    wr(8'h90, 1'b0, "after reload");
    wr(SOFT_RESET_PTR, 1'b0, "soft reset");
    i2c_master_model_i.stop_c();
    i2c_master_model_i.start_c();
    wr(8'h90, 1'b1, "busy addr");
    i2c_master_model_i.stop_c();
    chk(8'(n_reload), 8'h02, "reload ptr");
    $display("test soft reset done");
    repeat (RL) @(negedge core_clk);
    summarize();
  end
endmodule
